// *** hw/adc_channel_scan_control.sv ***
// channel select, scan sequencer and result store of the A/D converter
// Function
// - low select register enables channels 7..0
// - high select enables 11..8, bits 7..4 zero
// - enabled channels converted in ascending order
// - run stays zero when no channel selected
// - result only to converted channel's registers
// - run one starts scan at lowest channel
// - scan done interrupt after highest channel
// - continuous bit restarts, otherwise run clears
// - channel set frozen until scan completes
// - run zero stops conversion; resets to zero
// - result bits 9..2 high, 1..0 low
// - speed bit picks 13.5 or 43 us
//
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/1ns
module adc_channel_scan_control
  import adc_scan_pkg::*;
(
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic      [31:0]      hrdata,
  output logic                  hreadyout,
  output logic                  hresp,
  input  wire logic             conv_done,
  input  wire logic [RES_W-1:0] conv_data,
  output conv_req_type          conv_req,
  output logic                  scan_done_irq,
  output logic                  irq
);

  // bus phase state
  logic        wr_pend_r;   // write data phase pending
  logic        rd_pend_r;   // read data phase pending
  logic [15:0] addr_idx_r;  // latched register index
  logic        addr_ok_r;   // upper address bits were zero
  logic        hready_r;    // registered hreadyout
  logic [31:0] hrdata_r;    // registered read data
  // software visible registers
  logic [7:0]  sel_low_r;   // channels 7..0
  logic [3:0]  sel_high_r;  // channels 11..8
  logic        cont_r;      // continuous scan bit
  logic        speed_r;     // conversion speed bit
  logic        run_r;       // run bit
  logic        stat_r;      // sticky scan-done status
  logic        mask_r;      // interrupt enable
  logic [RES_W-1:0] result_mem [CHAN_NUM]; // per-channel results
  // sequencer state
  scan_state_type      state_r;
  logic [CHAN_NUM-1:0] active_set_r; // set captured at scan start
  logic [3:0]          cur_chan_r;   // channel being converted
  logic                done_seen_r;  // core reported done
  logic [11:0]         timer_r;      // conversion time left
  conv_req_type        conv_req_r;
  logic                scan_irq_r;
  logic                irq_r;
  // pin synchronisers
  logic             done_s1, done_s2, done_s3;
  logic [RES_W-1:0] data_s1, data_s2;
  // decode and derived terms
  logic                take;
  logic [CHAN_NUM-1:0] sel_all;
  logic wr_ctrl0, wr_ctrl1, wr_low, wr_high, wr_stat, wr_mask;
  logic run_wr1, run_wr0, scan_begin, conv_fin, scan_end, restart;
  logic done_rise;
  logic first_found, nxt_found;
  logic [3:0] first_idx, nxt_idx;
  logic [7:0]  rd_val;
  logic [15:0] res_off;
  assign take    = hsel && htrans[1] && hready;
  assign sel_all = {sel_high_r, sel_low_r};
  assign wr_ctrl0 = wr_pend_r && addr_ok_r && (addr_idx_r == IDX_CTRL0);
  assign wr_ctrl1 = wr_pend_r && addr_ok_r && (addr_idx_r == IDX_CTRL1);
  assign wr_low   = wr_pend_r && addr_ok_r && (addr_idx_r == IDX_SEL_LOW);
  assign wr_high  = wr_pend_r && addr_ok_r && (addr_idx_r == IDX_SEL_HIGH);
  assign wr_stat  = wr_pend_r && addr_ok_r && (addr_idx_r == IDX_IRQ_STAT);
  assign wr_mask  = wr_pend_r && addr_ok_r && (addr_idx_r == IDX_IRQ_MASK);
  assign run_wr1  = wr_ctrl1 && hwdata[RUN_BIT];
  assign run_wr0  = wr_ctrl1 && !hwdata[RUN_BIT];
  // a start with an empty selection is dropped
  assign scan_begin = run_wr1 && !run_r && (sel_all != 12'h000);
  assign done_rise  = done_s2 && !done_s3;
  // channel finished: core done and conversion time spent
  assign conv_fin = (state_r == ST_WAIT) && (done_seen_r || done_rise)
                    && (timer_r == 12'h000) && !run_wr0;
  assign scan_end = conv_fin && !nxt_found;
  assign restart  = scan_end && cont_r && (sel_all != 12'h000);
  assign res_off  = addr_idx_r - IDX_RES_BASE;

  // lowest channel of the captured set
  chan_finder u_first (
    .chan_set  (active_set_r),
    .from_idx  (4'h0),
    .found     (first_found),
    .found_idx (first_idx)
  );
  // next channel above the current one
  chan_finder u_next (
    .chan_set  (active_set_r),
    .from_idx  (cur_chan_r + 4'h1),
    .found     (nxt_found),
    .found_idx (nxt_idx)
  );
  // two-flop synchronisers for the core's done and data pins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {done_s3, done_s2, done_s1} <= 3'h0;
      {data_s2, data_s1}          <= {RES_RST, RES_RST};
    end else begin
      {done_s3, done_s2, done_s1} <= {done_s2, done_s1, conv_done};
      {data_s2, data_s1}          <= {data_s1, conv_data};
    end
  end
  // ahb address phase capture; reads take one wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r  <= 1'h0;
      rd_pend_r  <= 1'h0;
      addr_idx_r <= 16'h0000;
      addr_ok_r  <= 1'h0;
      hready_r   <= 1'h1;
      hrdata_r   <= 32'h0000_0000;
    end else begin
      wr_pend_r <= take && hwrite && (hsize == SIZE_WORD);
      rd_pend_r <= take && !hwrite;
      hready_r  <= !(take && !hwrite);
      // read data registered in the data phase, then held
      if (rd_pend_r) hrdata_r <= {24'h00_0000, rd_val};
      if (take) begin
        addr_idx_r <= haddr[17:2];
        addr_ok_r  <= (haddr[31:18] == ADDR_HI_ZERO);
      end
    end
  end
  // read multiplexer; unmapped indices read zero
  always_comb begin
    rd_val = 8'h00;
    if (addr_ok_r) begin
      case (addr_idx_r)
        IDX_CTRL0:    rd_val = {6'h00, speed_r, cont_r};
        IDX_CTRL1:    rd_val = {7'h00, run_r};
        IDX_SEL_LOW:  rd_val = sel_low_r;
        IDX_SEL_HIGH: rd_val = {4'h0, sel_high_r};
        IDX_IRQ_STAT: rd_val = {7'h00, stat_r};
        IDX_IRQ_MASK: rd_val = {7'h00, mask_r};
        default: begin
          if (addr_idx_r >= IDX_RES_BASE && res_off < RES_SPAN) begin
            if (res_off[0]) begin
              rd_val = result_mem[res_off[4:1]][RES_W-1:RES_LO_W];
            end else begin
              rd_val = {result_mem[res_off[4:1]][RES_LO_W-1:0],
                        6'h00};
            end
          end
        end
      endcase
    end
  end
  // channel select and control registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sel_low_r  <= SEL_RST;
      sel_high_r <= SEL_RST[3:0];
      cont_r     <= 1'h0;
      speed_r    <= 1'h0;
      mask_r     <= 1'h0;
    end else begin
      if (wr_low)   sel_low_r  <= hwdata[7:0];
      if (wr_high)  sel_high_r <= hwdata[3:0];
      if (wr_ctrl0) begin
        cont_r  <= hwdata[CONT_BIT];
        speed_r <= hwdata[SPEED_BIT];
      end
      if (wr_mask)  mask_r <= hwdata[STAT_BIT];
    end
  end
  // run bit: software start or stop, hardware clear at single scan end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_r <= 1'h0;
    end else if (run_wr0) begin
      run_r <= 1'h0;
    end else if (scan_begin) begin
      run_r <= 1'h1;
    end else if (scan_end && !restart) begin
      run_r <= 1'h0;
    end
  end
  // scan sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r      <= ST_IDLE;
      active_set_r <= 12'h000;
      cur_chan_r   <= 4'h0;
      done_seen_r  <= 1'h0;
      timer_r      <= 12'h000;
      conv_req_r   <= '0;
    end else begin
      conv_req_r.start <= 1'h0;
      if (run_wr0) begin
        state_r <= ST_IDLE;
      end else begin
        case (state_r)
          ST_IDLE: begin
            if (scan_begin) begin
              active_set_r <= sel_all;
              state_r      <= ST_FIRST;
            end
          end
          ST_FIRST: begin
            cur_chan_r <= first_idx;
            state_r    <= first_found ? ST_START : ST_IDLE;
          end
          ST_START: begin
            conv_req_r.start <= 1'h1;
            conv_req_r.chan  <= cur_chan_r;
            conv_req_r.speed <= speed_r;
            timer_r     <= speed_r ? SLOW_LOAD : FAST_LOAD;
            done_seen_r <= 1'h0;
            state_r     <= ST_WAIT;
          end
          ST_WAIT: begin
            if (timer_r != 12'h000) timer_r <= timer_r - 12'h001;
            if (done_rise) done_seen_r <= 1'h1;
            if (conv_fin) begin
              if (nxt_found) begin
                cur_chan_r <= nxt_idx;
                state_r    <= ST_START;
              end else if (restart) begin
                active_set_r <= sel_all;
                state_r      <= ST_FIRST;
              end else begin
                state_r <= ST_IDLE;
              end
            end
          end
          default: state_r <= ST_IDLE;
        endcase
      end
    end
  end
  // result store: only the channel just converted is written
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < CHAN_NUM; i++) result_mem[i] <= RES_RST;
    end else if (conv_fin) begin
      result_mem[cur_chan_r] <= data_s2;
    end
  end
  // scan done pulse, sticky status with set over clear, masked level
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scan_irq_r <= 1'h0;
      stat_r     <= 1'h0;
      irq_r      <= 1'h0;
    end else begin
      scan_irq_r <= scan_end;
      stat_r     <= (stat_r && !(wr_stat && hwdata[STAT_BIT])) || scan_end;
      irq_r      <= stat_r && mask_r;
    end
  end
  assign hrdata        = hrdata_r;
  assign hreadyout     = hready_r;
  assign hresp         = 1'h0;
  assign conv_req      = conv_req_r;
  assign scan_done_irq = scan_irq_r;
  assign irq           = irq_r;
  // helper for ordering checks: last started channel in this scan
  logic       first_conv_r;
  logic [3:0] last_chan_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      first_conv_r <= 1'h1;
      last_chan_r  <= 4'h0;
    end else if (state_r == ST_FIRST) begin
      first_conv_r <= 1'h1;
    end else if (conv_req_r.start) begin
      first_conv_r <= 1'h0;
      last_chan_r  <= conv_req_r.chan;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_low_sel_write: assert property (
    wr_low |=> sel_low_r == $past(hwdata[7:0]))
    else $error("low select register did not take write");
  a_high_upper_zero: assert property (
    (rd_pend_r && addr_ok_r && addr_idx_r == IDX_SEL_HIGH)
      |=> hrdata_r[7:4] == 4'h0 && hready_r)
    else $error("high select upper bits not zero");
  a_ascending_order: assert property (
    (conv_req_r.start && !first_conv_r) |-> conv_req_r.chan > last_chan_r)
    else $error("channels not converted in ascending order");
  a_empty_no_run: assert property (
    (run_wr1 && !run_r && sel_all == 12'h000)
      |=> !run_r && state_r == ST_IDLE)
    else $error("run set with no channel selected");
  a_result_sel_only: assert property (
    conv_fin |-> active_set_r[cur_chan_r])
    else $error("result written for disabled channel");
  a_start_lowest: assert property (
    (conv_req_r.start && first_conv_r) |-> conv_req_r.chan == first_idx)
    else $error("scan did not begin at lowest channel");
  a_single_stop: assert property (
    (scan_end && !restart) |=> !run_r && state_r == ST_IDLE)
    else $error("single scan did not stop");
  a_set_frozen: assert property (
    (state_r != ST_IDLE && !scan_end) |=> $stable(active_set_r))
    else $error("channel set changed during scan");
  a_stop_write: assert property (
    run_wr0 |=> !run_r && state_r == ST_IDLE && !conv_req_r.start)
    else $error("run zero did not stop the scan");
  a_one_conv: assert property (
    conv_req_r.start |=> !conv_req_r.start [*3])
    else $error("conversion started before previous finished");
  a_irq_pulse: assert property (
    scan_done_irq |=> !scan_done_irq)
    else $error("scan done request longer than one cycle");

  c_single_scan: cover property (scan_end && !cont_r);
  c_cont_restart: cover property (restart);
  c_stop_midscan: cover property (run_wr0 && state_r == ST_WAIT);
  c_multi_chan: cover property (conv_fin && nxt_found);

endmodule

// *** hw/adc_scan_pkg.sv ***
// shared constants, types and register map of the channel scan controller
package adc_scan_pkg;

  // channel count and width of one conversion result
  localparam int CHAN_NUM = 12;
  localparam int RES_W    = 10;

  // register indices; byte address on the bus is four times the index
  localparam logic [15:0] IDX_RES_BASE = 16'hf8d0; // chan n: low 2n, high 2n+1
  localparam logic [15:0] RES_SPAN     = 16'h0018; // 12 channels, two each
  localparam logic [15:0] IDX_CTRL0    = 16'hf8f0; // continuous and speed
  localparam logic [15:0] IDX_CTRL1    = 16'hf8f1; // run bit
  localparam logic [15:0] IDX_SEL_LOW  = 16'hf8f2; // channels 7..0
  localparam logic [15:0] IDX_SEL_HIGH = 16'hf8f3; // channels 11..8
  localparam logic [15:0] IDX_IRQ_STAT = 16'hf8f4; // sticky scan-done status
  localparam logic [15:0] IDX_IRQ_MASK = 16'hf8f5; // interrupt mask

  // field positions
  localparam int CONT_BIT  = 0; // continuous scan bit in ctrl0
  localparam int SPEED_BIT = 1; // conversion speed bit in ctrl0
  localparam int RUN_BIT   = 0; // run bit in ctrl1
  localparam int STAT_BIT  = 0; // scan done in status and mask
  localparam int RES_LO_W  = 2; // result bits kept in the low register
  localparam int RES_LO_SH = 6; // low result bits sit at 7..6

  // reset values
  localparam logic [7:0]  SEL_RST = 8'h00;
  localparam logic [RES_W-1:0] RES_RST = 10'h000;

  // bus constants
  localparam logic [2:0]  SIZE_WORD = 3'h2;
  localparam logic [13:0] ADDR_HI_ZERO = 14'h0000;

  // per-channel conversion times and their cycle counts
  localparam int CLK_PERIOD_NS = 20;
  localparam int FAST_CONV_NS  = 13500;
  localparam int SLOW_CONV_NS  = 43000;
  localparam int FAST_CYC = (FAST_CONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLOW_CYC = (SLOW_CONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [11:0] FAST_LOAD = 12'(FAST_CYC - 1);
  localparam logic [11:0] SLOW_LOAD = 12'(SLOW_CYC - 1);

  // scan sequencer states
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_FIRST = 2'b01,
    ST_START = 2'b10,
    ST_WAIT  = 2'b11
  } scan_state_type;

  // request toward the analog conversion core
  typedef struct packed {
    logic       start; // one-cycle start pulse
    logic [3:0] chan;  // channel to convert
    logic       speed; // 1 slow, 0 fast
  } conv_req_type;

endpackage

// *** hw/chan_finder.sv ***
// finds the lowest enabled channel at or above a start index
`timescale 1ns/1ns
module chan_finder
  import adc_scan_pkg::*;
(
  input  wire logic [CHAN_NUM-1:0] chan_set,
  input  wire logic [3:0]          from_idx,
  output logic                     found,
  output logic [3:0]               found_idx
);

  logic [CHAN_NUM-1:0] elig; // enabled and not below the start index

  // one eligibility term per channel
  genvar g;
  generate
    for (g = 0; g < CHAN_NUM; g++) begin : g_elig
      assign elig[g] = chan_set[g] && (4'(g) >= from_idx);
    end
  endgenerate

  // scan from the top so the lowest eligible channel wins
  always_comb begin
    found     = 1'h0;
    found_idx = 4'h0;
    for (int i = CHAN_NUM - 1; i >= 0; i--) begin
      if (elig[i]) begin
        found     = 1'h1;
        found_idx = 4'(i);
      end
    end
  end

endmodule

// *** tb/adc_core_model.sv ***
// behavioural model of the analog conversion core
`timescale 1ns/1ns
module adc_core_model
  import adc_scan_pkg::*;
(
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire conv_req_type     conv_req,
  input  wire integer           lat,
  output logic                  conv_done,
  output logic [RES_W-1:0]      conv_data
);
  int          cyc;        // free cycle count for time stamps
  int          left;       // cycles until the result is ready
  logic [3:0]  chan_q[$];  // channels in the order they were started
  logic        speed_q[$]; // speed bit seen with each start
  int          stamp_q[$]; // cycle of each start

  // one conversion at a time; done held until the next start
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cyc       <= 0;
      left      <= 0;
      conv_done <= 1'b0;
      conv_data <= 10'h155;
    end else begin
      cyc <= cyc + 1;
      // new start drops done and restarts the delay
      if (conv_req.start === 1'b1) begin
        chan_q.push_back(conv_req.chan);
        speed_q.push_back(conv_req.speed);
        stamp_q.push_back(cyc);
        conv_done <= 1'b0;
        left      <= lat;
        conv_data <= ~conv_data;
      end else if (left > 1) begin
        // data not valid yet: keep it moving
        left      <= left - 1;
        conv_data <= ~conv_data;
      end else if (left == 1) begin
        // result stands with done until the next start
        left      <= 0;
        conv_done <= 1'b1;
        conv_data <= {chan_q[$], ~chan_q[$], 2'b10};
      end
    end
  end
endmodule

// *** tb/tb_adc_channel_scan_control.sv ***
// self-checking bench of the channel scan controller
`timescale 1ns/1ns
module tb_adc_channel_scan_control
  import adc_scan_pkg::*;
;
  localparam int LIMIT = 40000;  // cycle ceiling of the whole run

  logic              hclk;
  logic              hresetn;
  logic              hsel;
  logic [31:0]       haddr;
  logic [1:0]        htrans;
  logic              hwrite;
  logic [2:0]        hsize;
  logic [31:0]       hwdata;
  logic              hready;
  logic [31:0]       hrdata;
  logic              hreadyout;
  logic              hresp;      // bus response, always okay
  logic              conv_done;
  logic [RES_W-1:0]  conv_data;
  conv_req_type      conv_req;
  logic              scan_done_irq;
  logic              irq;
  int                lat;        // partner answer delay
  int                cyc;        // timeout counter
  int                bad_count;
  int                n_checks;
  int                done_cnt;   // scan done pulses seen
  logic              pulse_prev; // last cycle's scan done level
  int                t0;
  int                n;

  assign hready = hreadyout;     // single slave on the bus

  adc_channel_scan_control i_dut (
    .hclk          (hclk),
    .hresetn       (hresetn),
    .hsel          (hsel),
    .haddr         (haddr),
    .htrans        (htrans),
    .hwrite        (hwrite),
    .hsize         (hsize),
    .hwdata        (hwdata),
    .hready        (hready),
    .hrdata        (hrdata),
    .hreadyout     (hreadyout),
    .hresp         (hresp),
    .conv_done     (conv_done),
    .conv_data     (conv_data),
    .conv_req      (conv_req),
    .scan_done_irq (scan_done_irq),
    .irq           (irq)
  );

  adc_core_model i_core (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .conv_req  (conv_req),
    .lat       (lat),
    .conv_done (conv_done),
    .conv_data (conv_data)
  );

  // 50 MHz clock
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  // byte address of a register index
  function automatic logic [31:0] adr(input logic [15:0] idx);
    return {ADDR_HI_ZERO, idx, 2'b00};
  endfunction

  // expected result of a channel and its register halves
  function automatic logic [9:0] res_of(input int ch);
    logic [3:0] c;
    c = 4'(ch);
    return {c, ~c, 2'b10};
  endfunction
  function automatic logic [31:0] res_hi(input int ch);
    logic [9:0] r;
    r = res_of(ch);
    return {24'h0, r[9:2]};
  endfunction
  function automatic logic [31:0] res_lo(input int ch);
    logic [9:0] r;
    r = res_of(ch);
    return {24'h0, r[1:0], 6'h00};
  endfunction

  // verdict and end of run
  task automatic stop_test();
    if (bad_count == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // compare and count
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // single word write: address phase, then data phase
  task automatic ahb_write(input logic [15:0] idx, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= adr(idx);
    hwrite <= 1'b1;
    hsize  <= SIZE_WORD;
    @(posedge hclk iff hready === 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk iff hready === 1'b1);
  endtask

  // single word read, data taken at the edge that ends the data phase
  task automatic ahb_read(input logic [15:0] idx, output logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= adr(idx);
    hwrite <= 1'b0;
    hsize  <= SIZE_WORD;
    @(posedge hclk iff hready === 1'b1);
    htrans <= 2'b00;
    @(posedge hclk iff hready === 1'b1);
    d = hrdata;
  endtask

  task automatic rd_chk(input logic [15:0] idx, input logic [31:0] exp,
                        input string name);
    logic [31:0] d;
    ahb_read(idx, d);
    check(name, d, exp);
    check("hresp_okay", {31'h0, hresp}, 32'h0);
  endtask

  task automatic wait_scans(input int k);
    while (done_cnt < k) @(posedge hclk);
  endtask

  // timeout and scan done pulse watch
  always @(posedge hclk) begin
    cyc++;
    if (scan_done_irq === 1'b1) begin
      done_cnt++;
      check("done_pulse_len", {31'h0, pulse_prev}, 32'h0);
    end
    pulse_prev <= scan_done_irq;
    if (cyc == LIMIT) begin
      bad_count++;
      stop_test();
    end
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h0;
    hwdata = 32'h0;
    lat = 10;
    cyc = 0;
    bad_count = 0;
    n_checks = 0;
    done_cnt = 0;
    pulse_prev = 1'b0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // reset values and access kinds
    rd_chk(IDX_SEL_LOW, 32'h0, "sel_low_rst");
    rd_chk(IDX_SEL_HIGH, 32'h0, "sel_high_rst");
    rd_chk(IDX_CTRL1, 32'h0, "run_rst");
    ahb_write(IDX_SEL_HIGH, 32'hff);
    rd_chk(IDX_SEL_HIGH, 32'h0f, "sel_high_rw");
    ahb_write(IDX_SEL_LOW, 32'ha5);
    rd_chk(IDX_SEL_LOW, 32'ha5, "sel_low_rw");
    rd_chk(16'hf8f6, 32'h0, "unmapped");
    // run with nothing selected is refused
    ahb_write(IDX_SEL_LOW, 32'h0);
    ahb_write(IDX_SEL_HIGH, 32'h0);
    ahb_write(IDX_CTRL1, 32'h1);
    repeat (20) @(posedge hclk);
    rd_chk(IDX_CTRL1, 32'h0, "run_empty");
    check("starts_empty", 32'(i_core.chan_q.size()), 32'h0);
    // single scan of channels 0 and 11 with a slow core
    lat <= 800;
    ahb_write(IDX_IRQ_MASK, 32'h1);
    ahb_write(IDX_SEL_LOW, 32'h01);
    ahb_write(IDX_SEL_HIGH, 32'h08);
    ahb_write(IDX_CTRL1, 32'h1);
    t0 = i_core.cyc;
    ahb_write(IDX_SEL_LOW, 32'h02);
    wait_scans(1);
    check("first_chan", 32'(i_core.chan_q[0]), 32'h0);
    check("start_delay", 32'((i_core.stamp_q[0] - t0) inside {[2:5]}), 1);
    check("second_chan", 32'(i_core.chan_q[1]), 32'd11);
    check("scan_len", 32'(i_core.chan_q.size()), 32'd2);
    t0 = i_core.stamp_q[1] - i_core.stamp_q[0];
    check("wait_done", 32'(t0 inside {[802:812]}), 32'h1);
    check("speed_fast", 32'(i_core.speed_q[1]), 32'h0);
    rd_chk(IDX_CTRL1, 32'h0, "run_cleared");
    rd_chk(IDX_RES_BASE, res_lo(0), "res0_low");
    rd_chk(IDX_RES_BASE + 16'd1, res_hi(0), "res0_high");
    rd_chk(IDX_RES_BASE + 16'd22, res_lo(11), "res11_low");
    rd_chk(IDX_RES_BASE + 16'd23, res_hi(11), "res11_high");
    rd_chk(IDX_RES_BASE + 16'd3, 32'h0, "res1_kept");
    // interrupt: raised, masked, cleared
    check("irq_set", {31'h0, irq}, 32'h1);
    rd_chk(IDX_IRQ_STAT, 32'h1, "stat_set");
    ahb_write(IDX_IRQ_MASK, 32'h0);
    repeat (2) @(posedge hclk);
    check("irq_masked", {31'h0, irq}, 32'h0);
    ahb_write(IDX_IRQ_MASK, 32'h1);
    ahb_write(IDX_IRQ_STAT, 32'h1);
    repeat (2) @(posedge hclk);
    check("irq_cleared", {31'h0, irq}, 32'h0);
    rd_chk(IDX_IRQ_STAT, 32'h0, "stat_cleared");
    // fast single scan of channels 0 and 1 with a prompt core
    lat <= 10;
    ahb_write(IDX_SEL_HIGH, 32'h0);
    ahb_write(IDX_SEL_LOW, 32'h03);
    ahb_write(IDX_CTRL1, 32'h1);
    wait_scans(2);
    t0 = i_core.stamp_q[3] - i_core.stamp_q[2];
    check("fast_period", 32'(t0 inside {[675:680]}), 32'h1);
    // continuous slow scan of channel 1
    ahb_write(IDX_SEL_LOW, 32'h02);
    ahb_write(IDX_CTRL0, 32'h3);
    ahb_write(IDX_CTRL1, 32'h1);
    wait_scans(4);
    n = i_core.chan_q.size();
    check("loop_chan", 32'(i_core.chan_q[n-1]), 32'h1);
    t0 = i_core.stamp_q[n-1] - i_core.stamp_q[n-2];
    check("slow_period", 32'(t0 inside {[2150:2158]}), 32'h1);
    check("speed_slow", 32'(i_core.speed_q[n-1]), 32'h1);
    rd_chk(IDX_CTRL1, 32'h1, "run_kept");
    rd_chk(IDX_RES_BASE + 16'd3, res_hi(1), "res1_high");
    rd_chk(IDX_RES_BASE + 16'd1, res_hi(0), "res0_kept");
    // stop in mid conversion
    repeat (300) @(posedge hclk);
    ahb_write(IDX_CTRL1, 32'h0);
    n = i_core.chan_q.size();
    t0 = done_cnt;
    repeat (2500) @(posedge hclk);
    check("no_restart", 32'(i_core.chan_q.size()), 32'(n));
    check("no_done", 32'(done_cnt), 32'(t0));
    rd_chk(IDX_CTRL1, 32'h0, "run_stopped");
    stop_test();
  end
endmodule
